/* verilog/aem_matcher.sv */
// Match logic of one access control entry for VLAN and IPv4 header criteria.

// Behaviour
// - VLAN don't-care ignores frame VLAN identifier.
// - Specific VLAN needs equal identifier, 1..4095.
// - Priority don't-care or one value 0..7.
// - Protocol don't-care ignores protocol number.
// - Specific protocol needs equal 8-bit number.
// - ICMP, UDP, TCP classes need IPv4 protocol.
// - TTL zero mode excludes nonzero TTL.
// - TTL nonzero mode needs TTL above zero.
// - Fragment no excludes fragmented IPv4 frames.
// - Fragment yes needs fragmented frames; any ignores.
// - Options no excludes frames carrying options.
// - Options yes needs options; any ignores.
// - Source don't-care ignores source address.
// - Host mode compares all source address bits.
// - Network mode compares only netmask-selected bits.
// - Frame type selects IPv4, ARP, Ethernet-type frames.
// - Matching frame is permitted or dropped by action.
module aem_matcher (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Entry criteria from management
  input wire aem_pkg::aem_cfg_s cfg_i,
  // Parsed frame header from the ingress pipeline
  input wire logic hdr_valid_i,
  input wire aem_pkg::aem_hdr_s hdr_i,
  // Verdict, one cycle after the header
  output logic result_valid_o,
  output logic match_o,
  output logic permit_o,
  output logic drop_o,
  output aem_pkg::aem_crit_s crit_o,
  // Entry holds a VLAN identifier outside the legal range
  output logic cfg_error_o
);

  function automatic logic ip_equal(input logic [aem_pkg::IP_ADDR_W-1:0] addr,
                                    input logic [aem_pkg::IP_ADDR_W-1:0] ref_addr,
                                    input logic [aem_pkg::IP_ADDR_W-1:0] mask);
    ip_equal = ((addr ^ ref_addr) & mask) == '0;
  endfunction : ip_equal

  function automatic logic proto_is(input aem_pkg::aem_hdr_s hdr,
                                    input logic [aem_pkg::PROTO_W-1:0] value);
    proto_is = hdr.is_ipv4 && (hdr.ip_proto == value);
  endfunction : proto_is

  logic vid_cfg_bad;
  logic ttl_nonzero;
  logic is_fragment;
  logic has_options;
  logic is_etype_frame;
  logic ttl_pass;
  logic frag_pass;
  logic opt_pass;
  aem_pkg::aem_crit_s crit;
  logic all_pass;

  logic valid_reg, valid_next;
  logic match_reg, match_next;
  logic permit_reg, permit_next;
  logic drop_reg, drop_next;
  logic cfg_err_reg, cfg_err_next;
  aem_pkg::aem_crit_s crit_reg, crit_next;

  // Header facts that the flag criteria test.
  assign ttl_nonzero = hdr_i.ttl != aem_pkg::TTL_ZERO;
  assign is_fragment = hdr_i.more_fragments_flag || (hdr_i.fragment_position != aem_pkg::FRAG_POS_ZERO);
  assign has_options = hdr_i.ihl > aem_pkg::IHL_NO_OPTIONS;
  // An IPv4 or ARP frame is never an Ethernet-type frame for matching purposes.
  assign is_etype_frame = !hdr_i.is_ipv4 && !hdr_i.is_arp && (hdr_i.ethertype >= aem_pkg::ETYPE_MIN);
  assign vid_cfg_bad = (cfg_i.vid_sel == aem_pkg::AEM_SEL_SPECIFIC) &&
                       (cfg_i.vlan_id < aem_pkg::VLAN_ID_MIN);

  aem_tri_check u_ttl_check (
    .mode_i(cfg_i.ttl_mode),
    .is_ipv4_i(hdr_i.is_ipv4),
    .cond_i(ttl_nonzero),
    .pass_o(ttl_pass)
  );

  aem_tri_check u_frag_check (
    .mode_i(cfg_i.frag_mode),
    .is_ipv4_i(hdr_i.is_ipv4),
    .cond_i(is_fragment),
    .pass_o(frag_pass)
  );

  aem_tri_check u_opt_check (
    .mode_i(cfg_i.opt_mode),
    .is_ipv4_i(hdr_i.is_ipv4),
    .cond_i(has_options),
    .pass_o(opt_pass)
  );

  always_comb
  begin
    crit = aem_pkg::CRIT_RST;
    case (cfg_i.frame_type)
      aem_pkg::AEM_FT_ANY: crit.ftype_ok = 1'b1;
      aem_pkg::AEM_FT_ETYPE: crit.ftype_ok = is_etype_frame;
      aem_pkg::AEM_FT_ARP: crit.ftype_ok = hdr_i.is_arp;
      aem_pkg::AEM_FT_IPV4: crit.ftype_ok = hdr_i.is_ipv4;
      default: crit.ftype_ok = 1'b0;
    endcase
    case (cfg_i.vid_sel)
      aem_pkg::AEM_SEL_ANY: crit.vid_ok = 1'b1;
      aem_pkg::AEM_SEL_SPECIFIC: crit.vid_ok = !vid_cfg_bad && (hdr_i.vlan_id == cfg_i.vlan_id);
      default: crit.vid_ok = 1'b0;
    endcase
    case (cfg_i.pcp_sel)
      aem_pkg::AEM_SEL_ANY: crit.pcp_ok = 1'b1;
      aem_pkg::AEM_SEL_SPECIFIC: crit.pcp_ok = hdr_i.pcp == cfg_i.pcp;
      default: crit.pcp_ok = 1'b0;
    endcase
    // Class modes only pin the protocol; their port criteria live elsewhere.
    case (cfg_i.proto_mode)
      aem_pkg::AEM_PROTO_ANY: crit.proto_ok = 1'b1;
      aem_pkg::AEM_PROTO_SPECIFIC: crit.proto_ok = proto_is(hdr_i, cfg_i.proto_value);
      aem_pkg::AEM_PROTO_ICMP: crit.proto_ok = proto_is(hdr_i, aem_pkg::PROTO_ICMP);
      aem_pkg::AEM_PROTO_UDP: crit.proto_ok = proto_is(hdr_i, aem_pkg::PROTO_UDP);
      aem_pkg::AEM_PROTO_TCP: crit.proto_ok = proto_is(hdr_i, aem_pkg::PROTO_TCP);
      default: crit.proto_ok = 1'b0;
    endcase
    crit.ttl_ok = ttl_pass;
    crit.frag_ok = frag_pass;
    crit.opt_ok = opt_pass;
    case (cfg_i.sip_mode)
      aem_pkg::AEM_SIP_ANY: crit.sip_ok = 1'b1;
      aem_pkg::AEM_SIP_HOST:
        crit.sip_ok = hdr_i.is_ipv4 &&
                      ip_equal(hdr_i.source_ip_address, cfg_i.source_ip_address, aem_pkg::IP_MASK_HOST);
      aem_pkg::AEM_SIP_NETWORK:
        crit.sip_ok = hdr_i.is_ipv4 &&
                      ip_equal(hdr_i.source_ip_address, cfg_i.source_ip_address, cfg_i.source_ip_netmask);
      default: crit.sip_ok = 1'b0;
    endcase
  end

  assign all_pass = &crit;

  always_comb
  begin
    valid_next = hdr_valid_i;
    cfg_err_next = vid_cfg_bad;
    // Verdict fields are cleared between headers so a stale match never lingers.
    crit_next = hdr_valid_i ? crit : aem_pkg::CRIT_RST;
    match_next = hdr_valid_i && all_pass;
    permit_next = match_next && (cfg_i.action == aem_pkg::AEM_ACT_PERMIT);
    drop_next = match_next && (cfg_i.action == aem_pkg::AEM_ACT_DENY);
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      valid_reg <= aem_pkg::RESULT_RST;
      match_reg <= aem_pkg::RESULT_RST;
      permit_reg <= aem_pkg::RESULT_RST;
      drop_reg <= aem_pkg::RESULT_RST;
      cfg_err_reg <= aem_pkg::RESULT_RST;
      crit_reg <= aem_pkg::CRIT_RST;
    end
    else
    begin
      valid_reg <= valid_next;
      match_reg <= match_next;
      permit_reg <= permit_next;
      drop_reg <= drop_next;
      cfg_err_reg <= cfg_err_next;
      crit_reg <= crit_next;
    end
  end

  assign result_valid_o = valid_reg;
  assign match_o = match_reg;
  assign permit_o = permit_reg;
  assign drop_o = drop_reg;
  assign crit_o = crit_reg;
  assign cfg_error_o = cfg_err_reg;

  AST_VID_ANY_IGNORED: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.vid_sel == aem_pkg::AEM_SEL_ANY |=> crit_o.vid_ok)
    else $error("VLAN don't-care rejected a frame");

  AST_VID_SPECIFIC: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.vid_sel == aem_pkg::AEM_SEL_SPECIFIC &&
    (hdr_i.vlan_id != cfg_i.vlan_id || cfg_i.vlan_id == 12'h000) |=> result_valid_o && !match_o)
    else $error("Frame matched with wrong or illegal VLAN identifier");

  AST_PCP: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.pcp_sel == aem_pkg::AEM_SEL_SPECIFIC |=>
    crit_o.pcp_ok == ($past(hdr_i.pcp) == $past(cfg_i.pcp)))
    else $error("Tag priority verdict wrong");

  AST_PROTO_SPECIFIC: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.proto_mode == aem_pkg::AEM_PROTO_SPECIFIC |=>
    crit_o.proto_ok == ($past(hdr_i.is_ipv4) && $past(hdr_i.ip_proto) == $past(cfg_i.proto_value)))
    else $error("Specific protocol verdict wrong");

  AST_PROTO_UDP: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.proto_mode == aem_pkg::AEM_PROTO_UDP && hdr_i.ip_proto != 8'h11 |=> !crit_o.proto_ok)
    else $error("UDP class accepted another protocol");

  AST_TTL_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.ttl_mode == aem_pkg::AEM_TRI_NO && hdr_i.ttl != 8'h00 |=> !match_o)
    else $error("Nonzero TTL matched a zero-TTL entry");

  AST_TTL_NONZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && hdr_i.is_ipv4 && cfg_i.ttl_mode == aem_pkg::AEM_TRI_YES |=>
    crit_o.ttl_ok == ($past(hdr_i.ttl) != 8'h00))
    else $error("Nonzero TTL verdict wrong");

  AST_FRAG_NO: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.frag_mode == aem_pkg::AEM_TRI_NO &&
    (hdr_i.more_fragments_flag || hdr_i.fragment_position != 13'h0000) |=> !match_o)
    else $error("Fragment matched a no-fragment entry");

  AST_OPT_YES: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && hdr_i.is_ipv4 && cfg_i.opt_mode == aem_pkg::AEM_TRI_YES |=>
    crit_o.opt_ok == ($past(hdr_i.ihl) > 4'h5))
    else $error("Options verdict wrong");

  AST_SIP_NET: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && hdr_i.is_ipv4 && cfg_i.sip_mode == aem_pkg::AEM_SIP_NETWORK |=>
    crit_o.sip_ok == ((($past(hdr_i.source_ip_address) ^ $past(cfg_i.source_ip_address)) &
                       $past(cfg_i.source_ip_netmask)) == 32'h00000000))
    else $error("Network source verdict wrong");

  AST_FTYPE_IPV4: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.frame_type == aem_pkg::AEM_FT_ETYPE && hdr_i.is_ipv4 |=> !match_o)
    else $error("IPv4 frame matched an Ethernet-type entry");

  AST_ACTION: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.action == aem_pkg::AEM_ACT_DENY |=> !permit_o && drop_o == match_o)
    else $error("Deny entry did not drop a match");

  AST_AND_ALL: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i |=> result_valid_o && match_o == (&crit_o))
    else $error("Match is not the AND of all criteria");

  AST_NON_IPV4: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && !hdr_i.is_ipv4 && cfg_i.sip_mode == aem_pkg::AEM_SIP_HOST |=> !match_o)
    else $error("Non-IPv4 frame passed a source address criterion");

  AST_PCP_ANY: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.pcp_sel == aem_pkg::AEM_SEL_ANY |=> crit_o.pcp_ok)
    else $error("Tag priority don't-care rejected a frame");

  AST_PROTO_ANY: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.proto_mode == aem_pkg::AEM_PROTO_ANY |=> crit_o.proto_ok)
    else $error("Protocol don't-care rejected a frame");

  AST_PROTO_TCP: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.proto_mode == aem_pkg::AEM_PROTO_TCP &&
    (!hdr_i.is_ipv4 || hdr_i.ip_proto != 8'h06) |=> !crit_o.proto_ok)
    else $error("TCP class accepted another frame");

  AST_TTL_ANY: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.ttl_mode == aem_pkg::AEM_TRI_ANY |=> crit_o.ttl_ok)
    else $error("TTL don't-care rejected a frame");

  AST_FRAG_YES: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && hdr_i.is_ipv4 && cfg_i.frag_mode == aem_pkg::AEM_TRI_YES |=>
    crit_o.frag_ok == ($past(hdr_i.more_fragments_flag) || $past(hdr_i.fragment_position) != 13'h0000))
    else $error("Fragment verdict wrong");

  AST_FRAG_ANY: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.frag_mode == aem_pkg::AEM_TRI_ANY |=> crit_o.frag_ok)
    else $error("Fragment don't-care rejected a frame");

  AST_OPT_NO: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.opt_mode == aem_pkg::AEM_TRI_NO && hdr_i.ihl > 4'h5 |=> !match_o)
    else $error("Frame with options matched a no-options entry");

  AST_OPT_ANY: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.opt_mode == aem_pkg::AEM_TRI_ANY |=> crit_o.opt_ok)
    else $error("Options don't-care rejected a frame");

  AST_SIP_ANY: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.sip_mode == aem_pkg::AEM_SIP_ANY |=> crit_o.sip_ok)
    else $error("Source don't-care rejected a frame");

  AST_SIP_HOST: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && hdr_i.is_ipv4 && cfg_i.sip_mode == aem_pkg::AEM_SIP_HOST |=>
    crit_o.sip_ok == ($past(hdr_i.source_ip_address) == $past(cfg_i.source_ip_address)))
    else $error("Host source verdict wrong");

  AST_FTYPE_ARP: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.frame_type == aem_pkg::AEM_FT_ETYPE && hdr_i.is_arp |=> !match_o)
    else $error("ARP frame matched an Ethernet-type entry");

  AST_PERMIT: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && cfg_i.action == aem_pkg::AEM_ACT_PERMIT |=> !drop_o && permit_o == match_o)
    else $error("Permit entry did not pass a match");

  AST_IDLE: assert property (@(posedge clk_i) disable iff (reset_i)
    !hdr_valid_i |=> !result_valid_o && !match_o && !permit_o && !drop_o && crit_o == 8'h00)
    else $error("Verdict outputs not idle without a header");

  AST_NON_IPV4_TTL: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_valid_i && !hdr_i.is_ipv4 && cfg_i.ttl_mode != aem_pkg::AEM_TRI_ANY |=> !crit_o.ttl_ok)
    else $error("Non-IPv4 frame passed a TTL criterion");

  AST_CFG_ERROR: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_i.vid_sel == aem_pkg::AEM_SEL_SPECIFIC && cfg_i.vlan_id == 12'h000 |=> cfg_error_o)
    else $error("Illegal VLAN identifier not flagged");

endmodule : aem_matcher

/* verilog/aem_pkg.sv */
// Shared constants and types for the access control entry matcher.
package aem_pkg;

  localparam int VLAN_ID_W = 12;
  localparam int PCP_W = 3;
  localparam int PROTO_W = 8;
  localparam int TTL_W = 8;
  localparam int FRAG_POS_W = 13;
  localparam int IHL_W = 4;
  localparam int IP_ADDR_W = 32;
  localparam int ETYPE_W = 16;

  localparam logic [VLAN_ID_W-1:0] VLAN_ID_MIN = 12'h001;
  localparam logic [VLAN_ID_W-1:0] VLAN_ID_MAX = 12'hfff;
  localparam logic [PROTO_W-1:0] PROTO_ICMP = 8'h01;
  localparam logic [PROTO_W-1:0] PROTO_TCP = 8'h06;
  localparam logic [PROTO_W-1:0] PROTO_UDP = 8'h11;
  localparam logic [ETYPE_W-1:0] ETYPE_MIN = 16'h0600;
  localparam logic [IHL_W-1:0] IHL_NO_OPTIONS = 4'h5;
  localparam logic [TTL_W-1:0] TTL_ZERO = 8'h00;
  localparam logic [FRAG_POS_W-1:0] FRAG_POS_ZERO = 13'h0000;
  localparam logic [IP_ADDR_W-1:0] IP_MASK_HOST = 32'hffffffff;

  // Cycles from an accepted header to its registered verdict.
  localparam int RESULT_LATENCY = 1;
  localparam logic RESULT_RST = 1'b0;

  typedef enum logic [0:0] {AEM_SEL_ANY, AEM_SEL_SPECIFIC} aem_sel_e;
  typedef enum logic [1:0] {AEM_TRI_ANY, AEM_TRI_NO, AEM_TRI_YES} aem_tri_e;
  typedef enum logic [2:0] {AEM_PROTO_ANY, AEM_PROTO_SPECIFIC, AEM_PROTO_ICMP, AEM_PROTO_UDP,
                            AEM_PROTO_TCP} aem_proto_e;
  typedef enum logic [1:0] {AEM_SIP_ANY, AEM_SIP_HOST, AEM_SIP_NETWORK} aem_sip_e;
  typedef enum logic [1:0] {AEM_FT_ANY, AEM_FT_ETYPE, AEM_FT_ARP, AEM_FT_IPV4} aem_ftype_e;
  typedef enum logic [0:0] {AEM_ACT_PERMIT, AEM_ACT_DENY} aem_action_e;

  // Parsed header facts of one frame.
  typedef struct packed {
    logic is_ipv4;
    logic is_arp;
    logic [ETYPE_W-1:0] ethertype;
    logic [VLAN_ID_W-1:0] vlan_id;
    logic [PCP_W-1:0] pcp;
    logic [PROTO_W-1:0] ip_proto;
    logic [TTL_W-1:0] ttl;
    logic more_fragments_flag;
    logic [FRAG_POS_W-1:0] fragment_position;
    logic [IHL_W-1:0] ihl;
    logic [IP_ADDR_W-1:0] source_ip_address;
  } aem_hdr_s;

  // Criteria of one access_control_entry.
  typedef struct packed {
    aem_ftype_e frame_type;
    aem_action_e action;
    aem_sel_e vid_sel;
    logic [VLAN_ID_W-1:0] vlan_id;
    aem_sel_e pcp_sel;
    logic [PCP_W-1:0] pcp;
    aem_proto_e proto_mode;
    logic [PROTO_W-1:0] proto_value;
    aem_tri_e ttl_mode;
    aem_tri_e frag_mode;
    aem_tri_e opt_mode;
    aem_sip_e sip_mode;
    logic [IP_ADDR_W-1:0] source_ip_address;
    logic [IP_ADDR_W-1:0] source_ip_netmask;
  } aem_cfg_s;

  // Pass bit of each criterion.
  typedef struct packed {
    logic ftype_ok;
    logic vid_ok;
    logic pcp_ok;
    logic proto_ok;
    logic ttl_ok;
    logic frag_ok;
    logic opt_ok;
    logic sip_ok;
  } aem_crit_s;

  localparam aem_crit_s CRIT_RST = 8'h00;

endpackage : aem_pkg

/* verilog/aem_tri_check.sv */
// Three-way IPv4 flag criterion: don't-care, flag must be clear, flag must be set.
module aem_tri_check (
  // Criterion setting
  input wire aem_pkg::aem_tri_e mode_i,
  // Frame facts
  input wire logic is_ipv4_i,
  input wire logic cond_i,
  // Verdict
  output logic pass_o
);

  always_comb
  begin
    case (mode_i)
      aem_pkg::AEM_TRI_ANY: pass_o = 1'b1;
      // Non-IPv4 frames fail any setting other than don't-care.
      aem_pkg::AEM_TRI_NO: pass_o = is_ipv4_i && !cond_i;
      aem_pkg::AEM_TRI_YES: pass_o = is_ipv4_i && cond_i;
      default: pass_o = 1'b0;
    endcase
  end

endmodule : aem_tri_check

/* dv/aem_parser_model.sv */
// Behavioural model of the ingress parser that hands parsed headers to the matcher.
module aem_parser_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Request from the bench
  input wire logic send_i,
  input wire aem_pkg::aem_hdr_s send_hdr_i,
  // Header towards the matcher
  output logic hdr_valid_o,
  output aem_pkg::aem_hdr_s hdr_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Between frames the bus inverts every cycle, so a read one cycle late sees the inverse of the last header.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      hdr_valid_o <= 1'b0;
      hdr_o <= '0;
    end
    else
    begin
      hdr_valid_o <= send_i;
      hdr_o <= send_i ? send_hdr_i : ~hdr_o;
    end
  end
endmodule : aem_parser_model

/* dv/test_aem_matcher.sv */
// Self-checking testbench of the access control entry matcher.
module test_aem_matcher;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i;
  logic reset_i;
  logic send;
  logic hdr_valid;
  logic result_valid_o;
  logic match_o;
  logic permit_o;
  logic drop_o;
  logic cfg_error_o;
  int mismatches;
  int check_count;
  aem_pkg::aem_cfg_s cfg;
  aem_pkg::aem_cfg_s cfg_q;
  aem_pkg::aem_hdr_s hdr;
  aem_pkg::aem_hdr_s hdr_q;
  aem_pkg::aem_hdr_s hdr_bus;
  aem_pkg::aem_crit_s crit_o;
  aem_pkg::aem_crit_s crit_seen;

  aem_parser_model i_aem_parser_model (.clk_i(clk_i), .reset_i(reset_i), .send_i(send), .send_hdr_i(hdr_q),
    .hdr_valid_o(hdr_valid), .hdr_o(hdr_bus));

  aem_matcher i_aem_matcher (.clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg_q), .hdr_valid_i(hdr_valid),
    .hdr_i(hdr_bus), .result_valid_o(result_valid_o), .match_o(match_o), .permit_o(permit_o),
    .drop_o(drop_o), .crit_o(crit_o), .cfg_error_o(cfg_error_o));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  // Plain IPv4 TCP frame and an entry that accepts anything.
  task automatic defaults();
    cfg = '0;
    hdr = '0;
    hdr.is_ipv4 = 1'b1;
    hdr.ethertype = 16'h0800;
    hdr.vlan_id = 12'h064;
    hdr.pcp = 3'h3;
    hdr.ip_proto = aem_pkg::PROTO_TCP;
    hdr.ttl = 8'h40;
    hdr.ihl = aem_pkg::IHL_NO_OPTIONS;
    hdr.source_ip_address = 32'h0a000001;
  endtask : defaults

  // One header through the parser model; the verdict must be a one-cycle pulse.
  task automatic run(input logic exp_m);
    int n;
    @(posedge clk_i);
    cfg_q <= cfg;
    hdr_q <= hdr;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    #1;
    n = 0;
    while (result_valid_o !== 1'b1 && n < 8)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 8)
    begin
      mismatches++;
      end_sim();
    end
    crit_seen = crit_o;
    chk("latency", n, aem_pkg::RESULT_LATENCY);
    chk("match", match_o, exp_m);
    chk("permit", permit_o, exp_m & (cfg.action == aem_pkg::AEM_ACT_PERMIT));
    chk("drop", drop_o, exp_m & (cfg.action == aem_pkg::AEM_ACT_DENY));
    @(posedge clk_i);
    #1;
    chk("valid_pulse", {result_valid_o, match_o}, 2'h0);
    chk("crit_idle", crit_o, 8'h00);
  endtask : run

  task automatic test_vlan();
    defaults();
    hdr.vlan_id = 12'hfff;
    run(1'b1);
    cfg.vid_sel = aem_pkg::AEM_SEL_SPECIFIC;
    cfg.vlan_id = aem_pkg::VLAN_ID_MAX;
    run(1'b1);
    chk("cfg_error_legal", cfg_error_o, 1'b0);
    hdr.vlan_id = 12'hffe;
    run(1'b0);
    cfg.vlan_id = 12'h000;
    hdr.vlan_id = 12'h000;
    run(1'b0);
    chk("cfg_error", cfg_error_o, 1'b1);
    chk("vid_ok", crit_seen.vid_ok, 1'b0);
  endtask : test_vlan

  task automatic test_pcp();
    for (int i = 0; i < 9; i++)
    begin
      defaults();
      cfg.pcp_sel = (i == 8) ? aem_pkg::AEM_SEL_ANY : aem_pkg::AEM_SEL_SPECIFIC;
      cfg.pcp = 3'(i);
      run(i == 3 || i == 8);
    end
  endtask : test_pcp

  task automatic test_proto();
    logic [7:0] p[3] = '{aem_pkg::PROTO_ICMP, aem_pkg::PROTO_UDP, aem_pkg::PROTO_TCP};
    for (int j = 0; j < 3; j++)
      for (int i = 0; i < 3; i++)
      begin
        defaults();
        cfg.proto_mode = aem_pkg::aem_proto_e'(j + 2);
        hdr.ip_proto = p[i];
        run(i == j);
      end
    defaults();
    hdr.ip_proto = 8'hff;
    run(1'b1);
    cfg.proto_mode = aem_pkg::AEM_PROTO_SPECIFIC;
    cfg.proto_value = 8'hff;
    run(1'b1);
    hdr.ip_proto = 8'hfe;
    run(1'b0);
  endtask : test_proto

  // Time-to-live, fragment (flag or offset) and options, each with any, clear and set.
  task automatic test_tri();
    aem_pkg::aem_tri_e m;
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 3; i++)
        for (int c = 0; c < 2; c++)
        begin
          defaults();
          m = aem_pkg::aem_tri_e'(i);
          cfg.ttl_mode = (k == 0) ? m : aem_pkg::AEM_TRI_ANY;
          cfg.frag_mode = (k == 1 || k == 2) ? m : aem_pkg::AEM_TRI_ANY;
          cfg.opt_mode = (k == 3) ? m : aem_pkg::AEM_TRI_ANY;
          hdr.ttl = (k == 0) ? 8'(c) : 8'h40;
          hdr.more_fragments_flag = (k == 1) && (c == 1);
          hdr.fragment_position = (k == 2) ? 13'(c) : 13'h0000;
          hdr.ihl = (k == 3 && c == 1) ? 4'h6 : 4'h5;
          run(i == 0 || (i == 2) == (c == 1));
        end
  endtask : test_tri

  task automatic test_source_addr();
    defaults();
    run(1'b1);
    cfg.sip_mode = aem_pkg::AEM_SIP_HOST;
    cfg.source_ip_address = 32'h0a000001;
    run(1'b1);
    hdr.source_ip_address = 32'h8a000001;
    run(1'b0);
    cfg.sip_mode = aem_pkg::AEM_SIP_NETWORK;
    cfg.source_ip_netmask = 32'h7fffff00;
    run(1'b1);
    hdr.source_ip_address = 32'h8a0001ff;
    run(1'b0);
  endtask : test_source_addr

  task automatic test_frame_type();
    defaults();
    cfg.frame_type = aem_pkg::AEM_FT_IPV4;
    cfg.action = aem_pkg::AEM_ACT_DENY;
    run(1'b1);
    cfg.frame_type = aem_pkg::AEM_FT_ETYPE;
    run(1'b0);
    hdr.is_ipv4 = 1'b0;
    hdr.ethertype = 16'h88cc;
    run(1'b1);
    cfg.ttl_mode = aem_pkg::AEM_TRI_YES;
    run(1'b0);
    chk("ttl_ok", crit_seen.ttl_ok, 1'b0);
    cfg.ttl_mode = aem_pkg::AEM_TRI_ANY;
    cfg.sip_mode = aem_pkg::AEM_SIP_HOST;
    cfg.source_ip_address = hdr.source_ip_address;
    run(1'b0);
    chk("sip_ok", crit_seen.sip_ok, 1'b0);
    // An ARP frame must not pass as an Ethernet-type frame even with a large type field.
    cfg.sip_mode = aem_pkg::AEM_SIP_ANY;
    hdr.is_arp = 1'b1;
    hdr.ethertype = 16'h0806;
    run(1'b0);
    chk("ftype_ok", crit_seen.ftype_ok, 1'b0);
    cfg.frame_type = aem_pkg::AEM_FT_ARP;
    run(1'b1);
  endtask : test_frame_type

  initial
  begin
    reset_i = 1'b1;
    send = 1'b0;
    mismatches = 0;
    check_count = 0;
    cfg_q = '0;
    hdr_q = '0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    test_vlan();
    test_pcp();
    test_proto();
    test_tri();
    test_source_addr();
    test_frame_type();
    end_sim();
  end
endmodule : test_aem_matcher
